// ==== common/tbrg_pkg.sv ====
// package: register map, field positions and timing constants for the baud rate timer
package tbrg_pkg;
	// apb register byte offsets
	localparam logic [7:0] TBRG_CTRL_OFS = 8'h00;
	localparam logic [7:0] TBRG_COUNT_OFS = 8'h04;
	localparam logic [7:0] TBRG_RELOAD_OFS = 8'h08;
	localparam logic [7:0] TBRG_STATUS_OFS = 8'h0c;
	localparam logic [7:0] TBRG_MASK_OFS = 8'h10;
	// second_timer_control field positions
	localparam int TBRG_RUN_BIT = 0;
	localparam int TBRG_CT_BIT = 1;
	localparam int TBRG_EXEN_BIT = 2;
	localparam int TBRG_TXSEL_BIT = 3;
	localparam int TBRG_RXSEL_BIT = 4;
	localparam int TBRG_CTRL_W = 5;
	// status and mask bit positions
	localparam int TBRG_ST_OVF = 0;
	localparam int TBRG_ST_EXT = 1;
	localparam int TBRG_ST_W = 2;
	// reset values
	localparam logic [4:0] TBRG_CTRL_RST = 5'h00;
	localparam logic [15:0] TBRG_COUNT_RST = 16'h0000;
	localparam logic [15:0] TBRG_RELOAD_RST = 16'h0000;
	localparam logic [1:0] TBRG_MASK_RST = 2'h0;
	// timing: one state time is two oscillator periods
	localparam int TBRG_OSC_PER_STATE = 2;
	localparam logic [15:0] TBRG_ALL_ONES = 16'hffff;
	// counter modes
	typedef enum logic [1:0] {
		TBRG_MODE_RELOAD = 2'b01,
		TBRG_MODE_BAUD = 2'b10
	} tbrg_mode_t;
endpackage : tbrg_pkg

// ==== core/tbrg_sync.sv ====
// three-stage input synchroniser with falling-edge detection
`timescale 1ns/1ns
module tbrg_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// pin and result
	input wire logic pin_in,
	output logic level,
	output logic fall
);
	logic s1;
	logic s2;
	logic s3;
	logic stable;
	// s1 feeds only s2; s2 and s3 decide edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else if (clk_en) begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// accepted level moves only once stages two and three agree, so a one-clock glitch is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable <= 1'b1;
		end else if (clk_en && (s2 == s3)) begin
			stable <= s3;
		end
	end
	assign level = stable;
	assign fall = clk_en & stable & ~s2 & ~s3;
endmodule : tbrg_sync

// ==== core/tbrg_timer.sv ====
// 16-bit auto-reload timer acting as serial baud rate generator, apb slave
`timescale 1ns/1ns
module tbrg_timer
	import tbrg_pkg::*;
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic external_trigger_pin,
	input wire logic event_pin,
	// other timer ticks and serial rate outputs
	input wire logic other_timer_tick,
	output logic rx_rate_tick,
	output logic tx_rate_tick,
	output logic baud_mode,
	// interrupt
	output logic irq
);
	import tbrg_pkg::*;

	// control, counter and flag registers
	logic [TBRG_CTRL_W-1:0] second_timer_control;
	logic [15:0] count;
	logic [15:0] reload;
	logic [TBRG_ST_W-1:0] status;
	logic [TBRG_ST_W-1:0] mask;

	// pin events and count strobes
	logic state_phase;
	logic trig_fall;
	logic evt_fall;
	logic inc;
	logic rollover;

	// apb decode
	logic wr;
	logic rd;
	logic hit_ctrl;
	logic hit_count;
	logic hit_reload;
	logic hit_status;
	logic hit_mask;
	logic [31:0] next_prdata;
	tbrg_mode_t mode;

	// flag set strobes and tick routing, bit 0 receive, bit 1 transmit
	logic [TBRG_ST_W-1:0] status_set;
	logic [1:0] tick_sel;
	logic [1:0] rate_tick;

	// pin synchronisers
	tbrg_sync u_trig (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin_in(external_trigger_pin),
		.level(),
		.fall(trig_fall)
	);
	tbrg_sync u_evt (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin_in(event_pin),
		.level(),
		.fall(evt_fall)
	);

	// mode select from the two clock select bits
	assign baud_mode = second_timer_control[TBRG_RXSEL_BIT] |
		second_timer_control[TBRG_TXSEL_BIT];
	assign mode = baud_mode ? TBRG_MODE_BAUD : TBRG_MODE_RELOAD;

	// address decode; apb answers with no wait state
	always_comb begin
		hit_ctrl = 1'b0;
		hit_count = 1'b0;
		hit_reload = 1'b0;
		hit_status = 1'b0;
		hit_mask = 1'b0;
		if (paddr == TBRG_CTRL_OFS) begin
			hit_ctrl = 1'b1;
		end else if (paddr == TBRG_COUNT_OFS) begin
			hit_count = 1'b1;
		end else if (paddr == TBRG_RELOAD_OFS) begin
			hit_reload = 1'b1;
		end else if (paddr == TBRG_STATUS_OFS) begin
			hit_status = 1'b1;
		end else if (paddr == TBRG_MASK_OFS) begin
			hit_mask = 1'b1;
		end
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable &
		~(hit_ctrl | hit_count | hit_reload | hit_status | hit_mask);
	// stalled clock enable also stalls register effects
	assign wr = clk_en & psel & penable & pwrite;
	assign rd = clk_en & psel & ~penable & ~pwrite;

	// read mux, captured in setup phase so data comes from a flop
	// a running count may be one state time old by the access edge
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_ctrl) begin
			next_prdata[TBRG_CTRL_W-1:0] = second_timer_control;
		end else if (hit_count) begin
			next_prdata[15:0] = count;
		end else if (hit_reload) begin
			next_prdata[15:0] = reload;
		end else if (hit_status) begin
			next_prdata[TBRG_ST_W-1:0] = status;
		end else if (hit_mask) begin
			next_prdata[TBRG_ST_W-1:0] = mask;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd) begin
			prdata <= next_prdata;
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_timer_control <= TBRG_CTRL_RST;
		end else if (wr && hit_ctrl) begin
			second_timer_control <= pwdata[TBRG_CTRL_W-1:0];
		end
	end

	// reload register; software writes it only while stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload <= TBRG_RELOAD_RST;
		end else if (wr && hit_reload) begin
			reload <= pwdata[15:0];
		end
	end

	// state-time divider: one increment per two oscillator periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_phase <= 1'b0;
		end else if (clk_en) begin
			state_phase <= ~state_phase;
		end
	end

	// count source: state times or external events
	always_comb begin
		if (!second_timer_control[TBRG_RUN_BIT]) begin
			inc = 1'b0;
		end else if (second_timer_control[TBRG_CT_BIT]) begin
			inc = evt_fall;
		end else begin
			inc = clk_en & state_phase;
		end
	end
	assign rollover = inc & (count == TBRG_ALL_ONES);

	// counter with reload on rollover; the period is 65536 minus reload
	// state times
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= TBRG_COUNT_RST;
		end else if (wr && hit_count) begin
			count <= pwdata[15:0];
		end else if (rollover) begin
			count <= reload;
		end else if (mode == TBRG_MODE_RELOAD && trig_fall &&
			second_timer_control[TBRG_EXEN_BIT]) begin
			count <= reload; // outside baud mode the pin forces a reload
		end else if (inc) begin
			count <= count + 16'h0001;
		end
	end

	// per-direction source select
	assign tick_sel = {second_timer_control[TBRG_TXSEL_BIT],
		second_timer_control[TBRG_RXSEL_BIT]};

	// rate ticks, registered one-cycle pulses; a flop keeps decode glitches off the serial side
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_tick
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rate_tick[ch] <= 1'b0;
				end else if (clk_en) begin
					rate_tick[ch] <= tick_sel[ch] ? rollover : other_timer_tick;
				end else begin
					rate_tick[ch] <= 1'b0;
				end
			end
		end
	endgenerate
	assign rx_rate_tick = rate_tick[0];
	assign tx_rate_tick = rate_tick[1];

	// flag set events; baud mode never raises the overflow flag
	assign status_set[TBRG_ST_OVF] = rollover & (mode == TBRG_MODE_RELOAD);
	assign status_set[TBRG_ST_EXT] = trig_fall &
		second_timer_control[TBRG_EXEN_BIT];

	// sticky status; hardware set wins so no event is lost to a late clear
	generate
		for (genvar b = 0; b < TBRG_ST_W; b++) begin : g_status
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status[b] <= 1'b0;
				end else if (status_set[b]) begin
					status[b] <= 1'b1;
				end else if (wr && hit_status && pwdata[b]) begin
					status[b] <= 1'b0;
				end
			end
		end
	endgenerate

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= TBRG_MASK_RST;
		end else if (wr && hit_mask) begin
			mask <= pwdata[TBRG_ST_W-1:0];
		end
	end

	// level interrupt from unmasked status
	assign irq = |(status & mask);
endmodule : tbrg_timer

// ==== sim/tbrg_assertions.sv ====
// port assertions for the baud rate timer
`timescale 1ns/1ns
module tbrg_assertions (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// rate ticks
	input wire logic other_timer_tick,
	input wire logic rx_rate_tick,
	input wire logic tx_rate_tick,
	input wire logic baud_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase on a word past the map
	wire logic acc_bad = psel && penable && paddr > 8'h10;
	property p_ready; psel |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err; acc_bad |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no pslverr");
	property p_ok; psel && penable && paddr[1:0] == 2'h0 && !acc_bad |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("pslverr on mapped word");
	property p_rd0; acc_bad && !pwrite |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	// ticks are single pulses, even at the shortest period
	property p_rxp; rx_rate_tick |=> !rx_rate_tick; endproperty
	a_rxp: assert property (p_rxp) else $error("rx tick too long");
	property p_txp; tx_rate_tick |=> !tx_rate_tick; endproperty
	a_txp: assert property (p_txp) else $error("tx tick too long");
	// no select set: both outputs follow the other timer
	property p_oth; !baud_mode && other_timer_tick |=> rx_rate_tick && tx_rate_tick; endproperty
	a_oth: assert property (p_oth) else $error("other tick lost");
	property p_noth; !baud_mode && !other_timer_tick |=> !rx_rate_tick && !tx_rate_tick;
	endproperty
	a_noth: assert property (p_noth) else $error("stray tick");
	c_baud: cover property (baud_mode && rx_rate_tick);
	c_both: cover property (rx_rate_tick && tx_rate_tick);
	c_err: cover property (pslverr);
endmodule : tbrg_assertions
bind tbrg_timer tbrg_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .other_timer_tick, .rx_rate_tick, .tx_rate_tick, .baud_mode);

// ==== sim/tbrg_serial_model.sv ====
// serial port side: the other timer's overflow ticks
`timescale 1ns/1ns
module tbrg_serial_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// tick toward the timer
	output logic other_timer_tick
);
	logic [3:0] div;
	// other timer overflows every sixteen clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 4'h0;
			other_timer_tick <= 1'b0;
		end else begin
			div <= div + 4'h1;
			other_timer_tick <= div == 4'hf;
		end
	end
endmodule : tbrg_serial_model

// ==== sim/tbrg_timer_test.sv ====
// self-checking bench for the baud rate timer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("Error %s exp %h got %h", nm, e, g); end end
module tbrg_timer_test;
	import tbrg_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, e;
	logic pready, pslverr, trig = 1'b1, evt = 1'b1, oth, rx_t, tx_t, baud, irq;
	logic [15:0] rl;
	logic [31:0] expq[$];
	int failures = 0, n_tests = 0, gap;
	always #2 pclk = ~pclk;
	tbrg_timer i_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .external_trigger_pin(trig), .event_pin(evt),
		.other_timer_tick(oth), .rx_rate_tick(rx_t), .tx_rate_tick(tx_t), .baud_mode(baud),
		.irq);
	tbrg_serial_model i_far (.pclk, .presetn, .other_timer_tick(oth));
	task automatic give_verdict;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	// read data meets the oldest expectation at the access edge
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = expq.pop_front();
			`CHK("prdata", e, prdata)
		end
	end
	// one apb transfer, held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
		if (k == 50) begin failures++; give_verdict(); end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		expq.push_back(x);
		xfer(1'b0, a, 32'h0);
	endtask : rd
	// clocks from now to the next tick of one output, bounded
	task automatic next_tick(input bit tx, output int g);
		g = 0;
		do begin @(posedge pclk); g++; end while ((tx ? tx_t : rx_t) !== 1'b1 && g < 600);
		if (g == 600) begin failures++; give_verdict(); end
	endtask : next_tick
	// clocks between two successive ticks of one output
	task automatic tick_gap(input bit tx, output int g);
		next_tick(tx, g);
		next_tick(tx, g);
	endtask : tick_gap
	// one falling edge on the trigger pin or the event pin
	task automatic pin_fall(input bit ev);
		if (ev) evt <= 1'b0;
		else trig <= 1'b0;
		repeat (8) @(posedge pclk);
		if (ev) evt <= 1'b1;
		else trig <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask : pin_fall
	initial begin
		void'($urandom(33496));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and a word past the map
		rd(TBRG_CTRL_OFS, 32'h0);
		rd(TBRG_RELOAD_OFS, 32'h0);
		rd(TBRG_MASK_OFS, 32'h0);
		rd(8'h14, 32'h0);
		tick_gap(1'b0, gap);
		`CHK("rx other", 16, gap)
		// reload loaded while stopped, then baud mode on rx only
		rl = {8'hff, 1'b0, 7'($urandom())};
		xfer(1'b1, TBRG_RELOAD_OFS, {16'h0, rl});
		xfer(1'b1, TBRG_COUNT_OFS, {16'h0, rl});
		xfer(1'b1, TBRG_CTRL_OFS, 32'h11);
		tick_gap(1'b0, gap);
		`CHK("rx gap", (65536 - int'(rl)) * 2, gap)
		tick_gap(1'b1, gap);
		`CHK("tx other", 16, gap)
		rd(TBRG_STATUS_OFS, 32'h0);
		rd(TBRG_RELOAD_OFS, {16'h0, rl});
		// both selects; pin edge without enable is ignored
		xfer(1'b1, TBRG_CTRL_OFS, 32'h19);
		tick_gap(1'b1, gap);
		`CHK("tx gap", (65536 - int'(rl)) * 2, gap)
		pin_fall(1'b0);
		rd(TBRG_STATUS_OFS, 32'h0);
		// with enable the edge flags, rate is kept, irq follows mask
		xfer(1'b1, TBRG_CTRL_OFS, 32'h1d);
		tick_gap(1'b0, gap);
		// the edge lands inside the measured period, so a reload would stretch it
		fork
			pin_fall(1'b0);
			next_tick(1'b0, gap);
		join
		`CHK("rx after edge", (65536 - int'(rl)) * 2, gap)
		rd(TBRG_STATUS_OFS, 32'h2);
		@(negedge pclk);
		`CHK("irq masked", 1'b0, irq)
		xfer(1'b1, TBRG_MASK_OFS, 32'h2);
		@(negedge pclk);
		`CHK("irq set", 1'b1, irq)
		xfer(1'b1, TBRG_STATUS_OFS, 32'h2);
		@(negedge pclk);
		`CHK("irq clear", 1'b0, irq)
		// plain auto-reload: overflow does flag
		xfer(1'b1, TBRG_CTRL_OFS, 32'h0);
		xfer(1'b1, TBRG_COUNT_OFS, 32'hfff0);
		xfer(1'b1, TBRG_CTRL_OFS, 32'h1);
		repeat (40) @(posedge pclk);
		rd(TBRG_STATUS_OFS, 32'h1);
		// counter mode counts event pin edges, not state times
		xfer(1'b1, TBRG_CTRL_OFS, 32'h0);
		xfer(1'b1, TBRG_STATUS_OFS, 32'h1);
		xfer(1'b1, TBRG_COUNT_OFS, 32'hfffe);
		xfer(1'b1, TBRG_CTRL_OFS, 32'h3);
		repeat (40) @(posedge pclk);
		rd(TBRG_STATUS_OFS, 32'h0);
		pin_fall(1'b1);
		pin_fall(1'b1);
		rd(TBRG_STATUS_OFS, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK("reads left", 0, expq.size())
		give_verdict();
	end
endmodule : tbrg_timer_test
